// *** inc/fnd_pkg.sv ***
// constants for the fractional-N serial control block
// assumes 32-bit serial words, three select bits in the low end
package fnd_pkg;
  localparam int          WORD_W   = 32;
  localparam int          NUM_LAT  = 8;
  localparam logic [2:0]  SEL_R0   = 3'h0;
  localparam logic [2:0]  SEL_R1   = 3'h1;
  localparam logic [2:0]  SEL_R2   = 3'h2;
  localparam logic [2:0]  SEL_R3   = 3'h3;
  // field positions
  localparam int          OSEL_HI  = 30;
  localparam int          OSEL_LO  = 27;
  localparam int          INT_HI   = 26;
  localparam int          INT_LO   = 15;
  localparam int          FMSB_HI  = 14;
  localparam int          FMSB_LO  = 3;
  localparam int          FLSB_HI  = 27;
  localparam int          FLSB_LO  = 15;
  localparam int          CUR_HI   = 27;
  localparam int          CUR_LO   = 24;
  localparam int          HALV_BIT = 21;
  localparam int          DBL_BIT  = 20;
  localparam int          RCNT_HI  = 19;
  localparam int          RCNT_LO  = 15;
  localparam int          PSK_BIT  = 9;
  localparam int          FSK_BIT  = 8;
  localparam int          PD_BIT   = 5;
  localparam int          CP3_BIT  = 4;
  // observation select codes
  localparam logic [3:0]  OBS_LOCK = 4'h1;
  localparam logic [3:0]  OBS_FB   = 4'h2;
  localparam logic [3:0]  OBS_REF  = 4'h3;
  // reference count field value 0 means divide by 32
  localparam logic [5:0]  RDIV_MAX = 6'h20;
  // bus map, word index
  localparam logic [3:0]  IDX_STAT = 4'h8;
  localparam logic [3:0]  IDX_CTRL = 4'h9;
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage

// *** hdl/fnd_serial_ctrl.sv ***
// fractional-N control: serial word loader, latches, reference divider,
// observation mux and AXI4-Lite status/control slave
// assumes host holds the load strobe high at least three CLOCK periods
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: shift register samples serial data on each serial clock rising edge.
// RULE2: host shifts msb first; select bits arrive last.
// RULE3: load strobe high moves shift word into latch picked by select bits.
// RULE4: power gate low powers down and floats the charge pump output.
// RULE5: observation output shows lock, scaled feedback or scaled reference.
// RULE6: keying data is applied to modulation in fsk or psk mode.
// RULE7: host programs integer ratios from 23 to 4095 only.
// RULE8: integer divide value held as a 12-bit number.
// RULE9: fractional modulus fixed at two to the 25.
// RULE10: fractional numerator accepts zero to modulus minus one.
// RULE11: pfd rate equals ref times (1+doubler) over count times (1+halver).
// RULE12: reference counter is 5 bits, dividing 1 to 32.
// RULE13: power-down disconnects the reference input buffer.
// RULE14: serial shift register is 32 bits long.
// RULE15: select bits as binary 0 to 7 pick the same-index latch.
// RULE16: fraction low, count, doubler, current, halver apply on register zero write.
// RULE17: a four-bit field picks the observation signal.
// RULE18: host keeps load strobe low while shifting, raises after last bit.
// RULE19: a load updates only the selected latch.
module fnd_serial_ctrl (
  // system
  input  wire logic                    CLOCK,
  input  wire logic                    RESETN,
  // serial port
  input  wire logic                    SER_CLK,
  input  wire logic                    SER_DATA,
  input  wire logic                    LOAD_STROBE,
  // pins
  input  wire logic                    POWER_GATE,
  input  wire logic                    KEYING_DATA_INPUT,
  input  wire logic                    REF_IN,
  input  wire logic                    LOCK_IN,
  input  wire logic                    FB_IN,
  output logic                         OBSERVATION_OUTPUT,
  output logic                         CHARGE_PUMP_OE,
  output logic                         REF_BUF_EN,
  output logic                         POWER_DOWN,
  output logic                         KEY_OUT,
  output logic                         PFD_TICK,
  // active settings
  output logic [11:0]                  INT_VALUE,
  output logic [24:0]                  FRACTIONAL_NUMERATOR,
  output logic [5:0]                   REF_COUNT,
  output logic                         DOUBLER,
  output logic                         REFERENCE_HALVER_SETTING,
  output logic [3:0]                   CP_CURRENT,
  // axi4-lite
  input  wire logic [7:0]              AWADDR,
  input  wire logic                    AWVALID,
  output logic                         AWREADY,
  input  wire logic [31:0]             WDATA,
  input  wire logic [3:0]              WSTRB,
  input  wire logic                    WVALID,
  output logic                         WREADY,
  output logic [1:0]                   BRESP,
  output logic                         BVALID,
  input  wire logic                    BREADY,
  input  wire logic [7:0]              ARADDR,
  input  wire logic                    ARVALID,
  output logic                         ARREADY,
  output logic [31:0]                  RDATA,
  output logic [1:0]                   RRESP,
  output logic                         RVALID,
  input  wire logic                    RREADY
);
  import fnd_pkg::*;

  logic [WORD_W-1:0] sr;
  logic [WORD_W-1:0] cap;
  logic [WORD_W-1:0] lat [NUM_LAT];
  logic              cap_v;
  logic              le_s1, le_s2, le_s3;
  logic              ce_s1, ce_s2;
  logic              key_s1, key_s2;
  logic              lock_s1, lock_s2;
  logic              fb_s1, fb_s2;
  logic              ref_s1, ref_s2, ref_s3;
  logic [5:0]        rc;
  logic              ht;
  logic              ref_lvl;
  logic              soft_pd;
  logic              aw_got, w_got;
  logic [7:0]        awa;
  logic [31:0]       wd;
  logic [3:0]        ws;

  // link side: only the shift register lives on the serial clock
  always_ff @(posedge SER_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sr <= RST_WORD;
    end else begin
      sr <= {sr[WORD_W-2:0], SER_DATA}; // RULE1 RULE2 RULE14
    end
  end

  a_shift_in: assert property (@(posedge SER_CLK) disable iff (!RESETN) 1'b1 |=> sr[0] == $past(SER_DATA)) // RULE1
    else $error("serial bit not captured");

  // pin synchronisers
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      {le_s1, le_s2, le_s3} <= 3'h0;
      {ce_s1, ce_s2} <= 2'h0;
      {key_s1, key_s2} <= 2'h0;
      {lock_s1, lock_s2} <= 2'h0;
      {fb_s1, fb_s2} <= 2'h0;
      {ref_s1, ref_s2, ref_s3} <= 3'h0;
    end else begin
      {le_s1, le_s2, le_s3} <= {LOAD_STROBE, le_s1, le_s2};
      {ce_s1, ce_s2} <= {POWER_GATE, ce_s1};
      {key_s1, key_s2} <= {KEYING_DATA_INPUT, key_s1};
      {lock_s1, lock_s2} <= {LOCK_IN, lock_s1};
      {fb_s1, fb_s2} <= {FB_IN, fb_s1};
      {ref_s1, ref_s2, ref_s3} <= {REF_IN, ref_s1, ref_s2};
    end
  end

  // the strobe qualifies the word: serial clock is idle while it is high
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cap   <= RST_WORD;
      cap_v <= 1'b0;
    end else begin
      cap_v <= le_s2 && !le_s3; // RULE3 RULE18
      if (le_s2 && !le_s3) begin
        cap <= sr;
      end
    end
  end

  wire logic [2:0]  csel    = cap[2:0];
  wire logic        r0_load = cap_v && csel == SEL_R0;
  wire logic [11:0] cap_int = cap[INT_HI:INT_LO];
  wire logic [11:0] cap_fm  = cap[FMSB_HI:FMSB_LO];

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < NUM_LAT; i++) begin
        lat[i] <= RST_WORD;
      end
    end else if (cap_v) begin
      lat[csel] <= cap; // RULE3 RULE15 RULE19
    end
  end

  a_latch_sel: assert property (@(posedge CLOCK) disable iff (!RESETN) cap_v |=> lat[$past(csel)] == $past(cap)) // RULE15
    else $error("selected latch not loaded");
  a_only_sel: assert property (@(posedge CLOCK) disable iff (!RESETN) cap_v && csel != SEL_R1 |=> $stable(lat[1])) // RULE19
    else $error("unselected latch changed");

  // double-buffered fields take effect only with a register zero load
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      INT_VALUE                <= 12'h0;
      FRACTIONAL_NUMERATOR     <= 25'h0;
      REF_COUNT                <= RDIV_MAX;
      DOUBLER                  <= 1'b0;
      REFERENCE_HALVER_SETTING <= 1'b0;
      CP_CURRENT               <= 4'h0;
    end else if (r0_load) begin
      INT_VALUE            <= cap_int; // RULE8 RULE7
      FRACTIONAL_NUMERATOR <= {cap_fm, lat[SEL_R1][FLSB_HI:FLSB_LO]}; // RULE9 RULE10 RULE16
      REF_COUNT            <= (lat[SEL_R2][RCNT_HI:RCNT_LO] == 5'h0) ? RDIV_MAX
                              : {1'b0, lat[SEL_R2][RCNT_HI:RCNT_LO]}; // RULE12
      DOUBLER                  <= lat[SEL_R2][DBL_BIT]; // RULE16
      REFERENCE_HALVER_SETTING <= lat[SEL_R2][HALV_BIT];
      CP_CURRENT               <= lat[SEL_R2][CUR_HI:CUR_LO];
    end
  end

  a_dbuf_hold: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !r0_load |=> $stable(FRACTIONAL_NUMERATOR) && $stable(REF_COUNT) && $stable(DOUBLER)) // RULE16
    else $error("buffered field moved without register zero");
  a_int_fractional_numerator: assert property (@(posedge CLOCK) disable iff (!RESETN)
    r0_load |=> INT_VALUE == $past(cap_int) && FRACTIONAL_NUMERATOR[24:13] == $past(cap_fm)) // RULE8
    else $error("integer or fraction wrong after load");

  // reference path: doubler counts both edges, halver drops every other tick
  wire logic ref_ev = (ref_s2 && !ref_s3) || (DOUBLER && !ref_s2 && ref_s3);

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rc       <= 6'h0;
      ht       <= 1'b0;
      ref_lvl  <= 1'b0;
      PFD_TICK <= 1'b0;
    end else begin
      PFD_TICK <= 1'b0;
      if (r0_load) begin
        // restart so a smaller new ratio never leaves the count past its end
        rc <= 6'h0;
        ht <= 1'b0;
      end else if (ref_ev) begin
        if (rc >= REF_COUNT - 6'h1) begin
          rc <= 6'h0; // RULE12
          ht <= !ht;
          if (!REFERENCE_HALVER_SETTING || ht) begin
            PFD_TICK <= 1'b1; // RULE11
            ref_lvl  <= !ref_lvl;
          end
        end else begin
          rc <= rc + 6'h1;
        end
      end
    end
  end

  a_ref_cnt: assert property (@(posedge CLOCK) disable iff (!RESETN) $past(r0_load) || rc < REF_COUNT) // RULE12
    else $error("reference counter past its ratio");

  // power gate, keying and observation
  wire logic [3:0] osel   = lat[SEL_R0][OSEL_HI:OSEL_LO];
  wire logic       pd     = !ce_s2 || lat[SEL_R3][PD_BIT] || soft_pd;
  wire logic       key_en = lat[SEL_R3][FSK_BIT] || lat[SEL_R3][PSK_BIT];

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      POWER_DOWN         <= 1'b1;
      CHARGE_PUMP_OE     <= 1'b0;
      REF_BUF_EN         <= 1'b0;
      KEY_OUT            <= 1'b0;
      OBSERVATION_OUTPUT <= 1'b0;
    end else begin
      POWER_DOWN     <= pd; // RULE4
      CHARGE_PUMP_OE <= !pd && !lat[SEL_R3][CP3_BIT]; // RULE4
      REF_BUF_EN     <= !pd; // RULE13
      KEY_OUT        <= key_en && !pd && key_s2; // RULE6
      case (osel) // RULE17
        OBS_LOCK: OBSERVATION_OUTPUT <= lock_s2; // RULE5
        OBS_FB:   OBSERVATION_OUTPUT <= fb_s2;
        OBS_REF:  OBSERVATION_OUTPUT <= ref_lvl;
        default:  OBSERVATION_OUTPUT <= 1'b0;
      endcase
    end
  end

  a_pd_float: assert property (@(posedge CLOCK) disable iff (!RESETN) !ce_s2 |=> POWER_DOWN && !CHARGE_PUMP_OE) // RULE4
    else $error("charge pump driven while gated off");
  a_ref_buf: assert property (@(posedge CLOCK) disable iff (!RESETN) POWER_DOWN == !REF_BUF_EN) // RULE13
    else $error("reference buffer loads pin in power-down");
  a_key_apply: assert property (@(posedge CLOCK) disable iff (!RESETN)
    key_en && !pd |=> KEY_OUT == $past(key_s2)) // RULE6
    else $error("keying data not applied");
  a_obs_lock: assert property (@(posedge CLOCK) disable iff (!RESETN)
    osel == OBS_LOCK |=> OBSERVATION_OUTPUT == $past(lock_s2)) // RULE5
    else $error("observation output not lock detect");

  // bus slave: word index in addr[5:2]
  function automatic logic fnd_mapped(input logic [7:0] a);
    return a[7:6] == 2'h0 && a[5:2] <= IDX_CTRL;
  endfunction

  wire logic wr_go = aw_got && w_got && !BVALID;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      awa     <= 8'h0;
      wd      <= RST_WORD;
      ws      <= 4'h0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OK;
      soft_pd <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got <= 1'b1;
        awa    <= AWADDR;
      end else if (BVALID && BREADY) begin
        aw_got <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_got <= 1'b1;
        wd    <= WDATA;
        ws    <= WSTRB;
      end else if (BVALID && BREADY) begin
        w_got <= 1'b0;
      end
      AWREADY <= !aw_got && !(AWVALID && AWREADY);
      WREADY  <= !w_got && !(WVALID && WREADY);
      if (wr_go) begin
        BVALID <= 1'b1;
        // only the control word is writable; latches come from the serial port
        BRESP  <= (awa[7:2] == {2'h0, IDX_CTRL}) ? RESP_OK : RESP_ERR;
        if (awa[7:2] == {2'h0, IDX_CTRL} && ws[0]) begin
          soft_pd <= wd[0];
        end
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= RST_WORD;
      RRESP   <= RESP_OK;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RRESP   <= fnd_mapped(ARADDR) ? RESP_OK : RESP_ERR;
      if (!fnd_mapped(ARADDR)) begin
        RDATA <= RST_WORD;
      end else if (ARADDR[5:2] == IDX_STAT) begin
        RDATA <= {28'h0, lock_s2, ce_s2, PFD_TICK, POWER_DOWN};
      end else if (ARADDR[5:2] == IDX_CTRL) begin
        RDATA <= {31'h0, soft_pd};
      end else begin
        RDATA <= lat[ARADDR[4:2]];
      end
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end else if (!RVALID && !ARREADY) begin
      ARREADY <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** tb/fnd_host_model.sv ***
// host side of the serial port: link clock, data and load strobe
// assumes CLOCK runs at least 3x faster than the strobe width
`timescale 1ns/1ps
`default_nettype none
module fnd_host_model (
  // serial port
  output var logic ser_clk,
  output var logic ser_data,
  output var logic load_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // link clock stands still between frames, 80 ns period inside
  task automatic send_word(input logic [31:0] w);
    #7;
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      #20 ser_clk = 1'b1;
      #40 ser_clk = 1'b0;
      #20;
    end
    // no pull on the line: stale bit must not look valid
    ser_data = ~w[0];
    #30 load_strobe = 1'b1;
    #100 load_strobe = 1'b0;
    #100;
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the fractional-N serial control block
// assumes fnd_pkg and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fnd_pkg::*;
  logic        CLOCK = 1'b0, RESETN = 1'b0, POWER_GATE = 1'b1, KEYING_DATA_INPUT = 1'b0;
  logic        REF_IN = 1'b0, LOCK_IN = 1'b0, FB_IN = 1'b0;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic        SER_CLK, SER_DATA, LOAD_STROBE, OBS, CP_OE, REF_EN, PD, KEY_OUT, TICK, DBL, HALV;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0]  AWADDR = 8'h0, ARADDR = 8'h0;
  logic [31:0] WDATA = 32'h0, RDATA, rd;
  logic [31:0] lat [8];
  logic [3:0]  WSTRB = 4'hf, CUR;
  logic [1:0]  BRESP, RRESP, resp, refdiv = 2'h0;
  logic [11:0] INT_VALUE;
  logic [24:0] FRACTIONAL_NUMERATOR_NUM;
  logic [5:0]  REF_COUNT;
  int          errors = 0, comparisons = 0, cycles = 0, gap;

  fnd_host_model host (.ser_clk(SER_CLK), .ser_data(SER_DATA), .load_strobe(LOAD_STROBE));
  fnd_serial_ctrl uut (.CLOCK(CLOCK), .RESETN(RESETN), .SER_CLK(SER_CLK), .SER_DATA(SER_DATA),
    .LOAD_STROBE(LOAD_STROBE), .POWER_GATE(POWER_GATE), .KEYING_DATA_INPUT(KEYING_DATA_INPUT),
    .REF_IN(REF_IN), .LOCK_IN(LOCK_IN), .FB_IN(FB_IN), .OBSERVATION_OUTPUT(OBS), .CHARGE_PUMP_OE(CP_OE),
    .REF_BUF_EN(REF_EN), .POWER_DOWN(PD), .KEY_OUT(KEY_OUT), .PFD_TICK(TICK), .INT_VALUE(INT_VALUE),
    .FRACTIONAL_NUMERATOR(FRACTIONAL_NUMERATOR_NUM), .REF_COUNT(REF_COUNT), .DOUBLER(DBL),
    .REFERENCE_HALVER_SETTING(HALV), .CP_CURRENT(CUR), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

  always #10 CLOCK = ~CLOCK;
  // reference period 8 cycles, slower than CLOCK/4
  always @(posedge CLOCK) begin
    refdiv <= refdiv + 2'h1;
    if (refdiv == 2'h3) REF_IN <= ~REF_IN;
  end
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    resp = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rd = RDATA;
    resp = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic ld(input logic [31:0] w);
    host.send_word(w);
    lat[w[2:0]] = w;
    @(posedge CLOCK);
  endtask

  task automatic t_dbuf();
    ld({8'h05, 4'h0, 5'h05, 12'h0, SEL_R2});
    ld({4'h0, 13'h1fff, 12'h0, SEL_R1});
    chk({REF_COUNT, FRACTIONAL_NUMERATOR_NUM}, {RDIV_MAX, 25'h0});
    ld({1'b0, OBS_LOCK, 12'hfff, 12'hfff, SEL_R0});
    chk(INT_VALUE, 12'hfff);
    chk(FRACTIONAL_NUMERATOR_NUM, 25'h1ffffff);
    chk({CUR, REF_COUNT}, {4'h5, 6'h05});
    ld(32'h5a5a5a5d);
    for (int i = 0; i < NUM_LAT; i++) begin
      axi_rd({i[5:0], 2'h0});
      chk(rd, lat[i]);
    end
  endtask
  task automatic t_obs();
    logic [3:0] code;
    for (int c = 0; c < 2; c++) begin
      code = OBS_LOCK + c[3:0];
      ld({1'b0, code, 12'd23, 12'h0, SEL_R0});
      for (int v = 0; v < 2; v++) begin
        LOCK_IN <= v[0];
        FB_IN <= ~v[0];
        wt(6);
        chk(OBS, (code == OBS_LOCK) ? v[0] : !v[0]);
      end
    end
    ld({1'b0, OBS_REF, 12'd23, 12'h0, SEL_R0});
    repeat (2) begin
      while (TICK !== 1'b1) @(posedge CLOCK);
      wt(1);
      rd[1] = rd[0];
      rd[0] = OBS;
    end
    chk(rd[0], !rd[1]);
  endtask
  task automatic t_key();
    for (int m = 0; m < 3; m++) begin
      ld({22'h0, m == 1, m == 0, 5'h0, SEL_R3});
      for (int v = 0; v < 2; v++) begin
        KEYING_DATA_INPUT <= v[0];
        wt(6);
        chk(KEY_OUT, v[0] & (m < 2));
      end
    end
  endtask
  // plain, doubled, halved, count field 0 meaning 32
  task automatic t_pfd();
    for (int d = 0; d < 4; d++) begin
      ld({8'h05, 2'h0, d == 2, d == 1, (d == 3) ? 5'h0 : 5'h5, 12'h0, SEL_R2});
      ld({1'b0, OBS_LOCK, 12'd23, 12'h0, SEL_R0});
      chk({DBL, HALV}, {d == 1, d == 2});
      while (TICK !== 1'b1) @(posedge CLOCK);
      // first gap may straddle the settings change
      repeat (2) begin
        gap = 0;
        do begin
          @(posedge CLOCK);
          gap++;
        end while (TICK !== 1'b1 && gap < 600);
      end
      chk(gap, 8 * ((d == 3) ? 32 : 5) * ((d == 2) ? 2 : 1) / ((d == 1) ? 2 : 1));
    end
  endtask
  task automatic t_bus();
    POWER_GATE <= 1'b0;
    wt(5);
    chk({PD, CP_OE, REF_EN}, 3'b100);
    POWER_GATE <= 1'b1;
    axi_wr(8'h24, 32'h1);
    wt(5);
    chk({resp, PD}, {RESP_OK, 1'b1});
    axi_rd(8'h24);
    chk(rd, 32'h1);
    axi_wr(8'h24, 32'h0);
    axi_wr(8'h00, 32'hffffffff);
    chk(resp, RESP_ERR);
    axi_rd(8'h40);
    chk({resp, rd[29:0]}, {RESP_ERR, 30'h0});
    axi_rd(8'h00);
    chk({PD, rd}, {1'b0, lat[0]});
    axi_rd(8'h20);
    chk({rd[31:2], rd[0]}, {28'h0, 2'b11, 1'b0});
    ld({26'h0, 3'b100, SEL_R3});
    chk({PD, CP_OE, REF_EN}, 3'b100);
    ld({26'h0, 3'b010, SEL_R3});
    chk({PD, CP_OE, REF_EN}, 3'b001);
    ld({29'h0, SEL_R3});
  endtask

  initial begin
    foreach (lat[i]) lat[i] = 32'h0;
    wt(2);
    chk({PD, CP_OE, REF_COUNT}, {2'b10, RDIV_MAX});
    RESETN <= 1'b1;
    wt(5);
    chk({PD, CP_OE, REF_EN}, 3'b011);
    t_dbuf();
    t_obs();
    t_key();
    t_pfd();
    t_bus();
    tally_and_finish();
  end
endmodule
`default_nettype wire
